//--- verilog/pll_pkg.sv
// package: register map, serial framing and field layout of the synth core
package pll_pkg;
  localparam int LOOP_W  = 16;
  localparam int REF_W   = 15;
  localparam int CFG_W   = 8;
  localparam int SHIFT_W = 24;
  localparam int CNT_W   = 6;

  // clock counts that select the target register
  localparam logic [CNT_W-1:0] CFG_MAX_BITS  = 6'h08;
  localparam logic [CNT_W-1:0] LOOP_MAX_BITS = 6'h10;
  localparam logic [CNT_W-1:0] CNT_SAT       = 6'h3F;

  // byte addresses of the bus registers
  localparam logic [7:0] OFS_LOOP   = 8'h00;
  localparam logic [7:0] OFS_REF    = 8'h04;
  localparam logic [7:0] OFS_CFG    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // reset values
  localparam logic [LOOP_W-1:0] LOOP_RST = 16'h0028;
  localparam logic [REF_W-1:0]  REF_RST  = 15'h0001;
  localparam logic [CFG_W-1:0]  CFG_RST  = 8'h00;

  // configuration bit positions
  localparam int CFG_DIV_EN  = 0;
  localparam int CFG_PD_EN   = 1;
  localparam int CFG_LOCK_EN = 2;
  localparam int CFG_REF_EN  = 3;
  localparam int CFG_PD_INV  = 4;

  // status bit positions
  localparam int ST_UP    = 0;
  localparam int ST_DN    = 1;
  localparam int ST_LOCK  = 2;
  localparam int ST_LOADS = 8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic [CNT_W-1:0]   bits;
    logic [SHIFT_W-1:0] data;
  } frame_s;

  typedef struct packed {
    logic [2:0] spare;
    logic       pd_inv;
    logic       ref_en;
    logic       lock_en;
    logic       pd_en;
    logic       div_en;
  } cfg_s;
endpackage

//--- verilog/serial_shift.sv
// serial shift register on the link clock, holds the last frame
`timescale 1ns/1ns
module serial_shift
  import pll_pkg::*;
(
  // link
  input  wire logic sclk,
  input  wire logic hresetn,
  input  wire logic enb_n,
  input  wire logic sdin,
  // to core domain
  output frame_s    frame,
  output logic      frame_tgl
);
  logic               open_reg;
  logic [CNT_W-1:0]   bits_reg;
  logic [SHIFT_W-1:0] shift_reg;
  logic               tgl_reg;

  // the link clock stops between frames, so release clears this flag;
  // reset clears it too, else the first frame after power-up is lost
  always_ff @(posedge sclk or posedge enb_n or negedge hresetn) begin
    if (!hresetn) begin
      open_reg <= 1'b0;
    end else if (enb_n) begin
      open_reg <= 1'b0;
    end else begin
      open_reg <= 1'b1;
    end
  end

  // bit count and data survive the release for the core to read
  always_ff @(posedge sclk or negedge hresetn) begin
    if (!hresetn) begin
      bits_reg  <= '0;
      shift_reg <= '0;
      tgl_reg   <= 1'b0;
    end else if (!enb_n) begin
      shift_reg <= {shift_reg[SHIFT_W-2:0], sdin};
      if (!open_reg) begin
        bits_reg <= 6'h01;
        tgl_reg  <= ~tgl_reg;
      end else if (bits_reg != CNT_SAT) begin
        bits_reg <= bits_reg + 6'h01;
      end
    end
  end

  assign frame     = '{bits: bits_reg, data: shift_reg};
  assign frame_tgl = tgl_reg;
endmodule // serial_shift

//--- verilog/div_counter.sv
// programmable down counter with jam-load
`timescale 1ns/1ns
module div_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // control
  input  wire logic         tick,
  input  wire logic         jam,
  input  wire logic [W-1:0] ratio,
  // divided output
  output logic              pulse_reg
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end else if (jam) begin
      cnt_reg   <= ratio;
      pulse_reg <= 1'b0;
    end else if (tick) begin
      // a count of one or less reloads, so ratio 1 passes every tick
      if (cnt_reg <= W'(1)) begin
        cnt_reg   <= ratio;
        pulse_reg <= 1'b1;
      end else begin
        cnt_reg   <= cnt_reg - W'(1);
        pulse_reg <= 1'b0;
      end
    end else begin
      pulse_reg <= 1'b0;
    end
  end
endmodule // div_counter

//--- verilog/pll_synth_core.sv
// digital core of the synthesizer: serial loads, dividers, phase detector
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module pll_synth_core
  import pll_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial link from the host
  input  wire logic        sclk,
  input  wire logic        enb_n,
  input  wire logic        sdin,
  // frequency inputs
  input  wire logic        osc_in,
  input  wire logic        fin_in,
  // synthesizer outputs
  output logic             fr_out,
  output logic             fv_out,
  output logic             phi_r_out,
  output logic             phi_v_out,
  output logic             lock_out,
  output logic             ref_out
);
  // link side
  frame_s             frame;
  logic               frame_tgl;

  // crossings
  logic               enb_s1_reg;
  logic               enb_s2_reg;
  logic               enb_s3_reg;
  logic               tgl_s1_reg;
  logic               tgl_s2_reg;
  logic               tgl_seen_reg;
  logic               osc_s1_reg;
  logic               osc_s2_reg;
  logic               osc_s3_reg;
  logic               fin_s1_reg;
  logic               fin_s2_reg;
  logic               fin_s3_reg;

  // registers
  logic [LOOP_W-1:0]  loop_div_reg;
  logic [REF_W-1:0]   ref_div_reg;
  cfg_s               cfg_reg;
  logic               jam_reg;
  logic [7:0]         loads_reg;

  // bus
  logic               wr_pend_reg;
  logic [7:0]         wr_addr_reg;
  logic [31:0]        rdata_next;

  // dividers and phase detector
  logic               osc_tick;
  logic               fin_tick;
  logic               fr_pulse;
  logic               fv_pulse;
  logic               up_reg;
  logic               dn_reg;

  // decoded events
  logic               frame_end;
  logic               frame_new;
  logic               commit;
  logic               to_cfg;
  logic               to_loop;
  logic               to_ref;
  logic               addr_ok;
  logic               bus_wr_loop;
  logic               bus_wr_ref;
  logic               bus_wr_cfg;

  serial_shift u_shift (
    .sclk      (sclk),
    .hresetn   (hresetn),
    .enb_n     (enb_n),
    .sdin      (sdin),
    .frame     (frame),
    .frame_tgl (frame_tgl)
  );

  // ---- clock domain crossings ----
  // link signals are held stable by the stopped link clock once enable
  // is seen high here, so the frame word is read only after that point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enb_s1_reg <= 1'b1;
      enb_s2_reg <= 1'b1;
      enb_s3_reg <= 1'b1;
    end else begin
      enb_s1_reg <= enb_n;
      enb_s2_reg <= enb_s1_reg;
      enb_s3_reg <= enb_s2_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= frame_tgl;
      tgl_s2_reg <= tgl_s1_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      fin_s1_reg <= 1'b0;
      fin_s2_reg <= 1'b0;
      fin_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      fin_s1_reg <= fin_in;
      fin_s2_reg <= fin_s1_reg;
      fin_s3_reg <= fin_s2_reg;
    end
  end

  // inputs are counted on their rising edges; each must stay below
  // half the core clock rate or edges are lost
  assign osc_tick = osc_s2_reg & ~osc_s3_reg;
  assign fin_tick = fin_s2_reg & ~fin_s3_reg;

  // ---- serial frame commit ----
  assign frame_end = enb_s2_reg & ~enb_s3_reg;
  // a frame with no clocks leaves the toggle alone and commits nothing
  assign frame_new = tgl_s2_reg ^ tgl_seen_reg;
  assign commit    = frame_end & frame_new;

  // the count alone picks the register, no address in the stream
  assign to_cfg  = commit && frame.bits <= CFG_MAX_BITS;
  assign to_loop = commit && frame.bits > CFG_MAX_BITS
                          && frame.bits <= LOOP_MAX_BITS;
  assign to_ref  = commit && frame.bits > LOOP_MAX_BITS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_seen_reg <= 1'b0;
    end else if (frame_end) begin
      tgl_seen_reg <= tgl_s2_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loads_reg <= '0;
    end else if (commit) begin
      loads_reg <= loads_reg + 8'h01;
    end
  end

  // ---- bus decode ----
  assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ
                        && hsize == HSIZE_WORD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (hready) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // a serial load in the same cycle takes precedence over the bus
  assign bus_wr_loop = wr_pend_reg && wr_addr_reg == OFS_LOOP;
  assign bus_wr_ref  = wr_pend_reg && wr_addr_reg == OFS_REF;
  assign bus_wr_cfg  = wr_pend_reg && wr_addr_reg == OFS_CFG;

  // ---- divide and configuration registers ----
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_div_reg <= LOOP_RST;
    end else if (to_loop) begin
      loop_div_reg <= frame.data[LOOP_W-1:0];
    end else if (bus_wr_loop && !commit) begin
      loop_div_reg <= hwdata[LOOP_W-1:0];
    end
  end

  // ratios 2 to 4 and loop ratios below 40 are not trapped here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_div_reg <= REF_RST;
    end else if (to_ref) begin
      ref_div_reg <= frame.data[REF_W-1:0];
    end else if (bus_wr_ref && !to_loop) begin
      ref_div_reg <= hwdata[REF_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= CFG_RST;
    end else if (to_cfg) begin
      cfg_reg <= frame.data[CFG_W-1:0];
    end else if (bus_wr_cfg && !commit) begin
      cfg_reg <= hwdata[CFG_W-1:0];
    end
  end

  // one jam pulse feeds both counters so they restart on the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jam_reg <= 1'b0;
    end else begin
      jam_reg <= to_loop || (bus_wr_loop && !commit);
    end
  end

  // ---- dividers ----
  div_counter #(.W(REF_W)) u_ref_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tick      (osc_tick),
    .jam       (jam_reg),
    .ratio     (ref_div_reg),
    .pulse_reg (fr_pulse)
  );

  div_counter #(.W(LOOP_W)) u_loop_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tick      (fin_tick),
    .jam       (jam_reg),
    .ratio     (loop_div_reg),
    .pulse_reg (fv_pulse)
  );

  // ---- phase-frequency detector ----
  // both pending means the edges met: clear instead of holding both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else if (jam_reg) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else if ((up_reg || fr_pulse) && (dn_reg || fv_pulse)) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      up_reg <= up_reg || fr_pulse;
      dn_reg <= dn_reg || fv_pulse;
    end
  end

  // ---- outputs, each held low when its enable bit is clear ----
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fr_out <= 1'b0;
      fv_out <= 1'b0;
    end else begin
      fr_out <= cfg_reg.div_en & fr_pulse;
      fv_out <= cfg_reg.div_en & fv_pulse;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phi_r_out <= 1'b0;
      phi_v_out <= 1'b0;
    end else if (!cfg_reg.pd_en) begin
      phi_r_out <= 1'b0;
      phi_v_out <= 1'b0;
    end else if (cfg_reg.pd_inv) begin
      phi_r_out <= dn_reg;
      phi_v_out <= up_reg;
    end else begin
      phi_r_out <= up_reg;
      phi_v_out <= dn_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_out <= 1'b0;
      ref_out  <= 1'b0;
    end else begin
      lock_out <= cfg_reg.lock_en & ~up_reg & ~dn_reg;
      ref_out  <= cfg_reg.ref_en & osc_s2_reg;
    end
  end

  // ---- read data, registered in the address phase ----
  always_comb begin
    rdata_next = '0;
    unique case (haddr[7:0])
      OFS_LOOP:   rdata_next[LOOP_W-1:0] = loop_div_reg;
      OFS_REF:    rdata_next[REF_W-1:0]  = ref_div_reg;
      OFS_CFG:    rdata_next[CFG_W-1:0]  = cfg_reg;
      OFS_STATUS: begin
        rdata_next[ST_UP]   = up_reg;
        rdata_next[ST_DN]   = dn_reg;
        rdata_next[ST_LOCK] = ~up_reg & ~dn_reg;
        rdata_next[ST_LOADS +: 8] = loads_reg;
      end
      default:    rdata_next = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule // pll_synth_core

//--- bench/pll_synth_core_asserts.sv
// checker: bus answers, quiet outputs and jam timing of the synth core
`timescale 1ns/1ns
module pll_synth_core_asserts
  import pll_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // outputs
  input wire logic        fr_out,
  input wire logic        fv_out,
  input wire logic        phi_r_out,
  input wire logic        phi_v_out,
  input wire logic        lock_out,
  input wire logic        ref_out
);
  logic rd_q;
  logic bad_q;
  logic wl_q;
  wire  req = hsel && hready && htrans == HTRANS_NONSEQ;
  wire  word = hsize == HSIZE_WORD;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q  <= 1'h0;
      bad_q <= 1'h0;
      wl_q  <= 1'h0;
    end else begin
      rd_q  <= req && !hwrite;
      bad_q <= req && !hwrite && word &&
               (haddr[7:0] > OFS_STATUS || haddr[1:0] != 2'h0);
      wl_q  <= req && hwrite && word && haddr[7:0] == OFS_LOOP;
    end
  end
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_rdata_held: assert property (!rd_q |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (bad_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_quiet_reset: assert property ($rose(hresetn) |->
    !(fr_out || fv_out || phi_r_out || phi_v_out || lock_out || ref_out))
    else $error("output active after reset");
  a_lock_clear: assert property (lock_out |-> !phi_r_out && !phi_v_out)
    else $error("lock with detector active");
  a_fr_single: assert property (fr_out |=> !fr_out)
    else $error("reference pulse too long");
  a_jam_pd_clear: assert property (wl_q |-> ##[1:4]
    !(phi_r_out || phi_v_out))
    else $error("detector not cleared by jam");
  c_loop_write: cover property (wl_q);
  c_both_pulse: cover property (fr_out && fv_out);
  c_lock_seen: cover property (lock_out);
  c_swap_seen: cover property (phi_v_out && !phi_r_out);
endmodule // pll_synth_core_asserts

bind pll_synth_core pll_synth_core_asserts chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .fr_out(fr_out), .fv_out(fv_out), .phi_r_out(phi_r_out),
  .phi_v_out(phi_v_out), .lock_out(lock_out), .ref_out(ref_out)
);

//--- bench/spi_host_model.sv
// serial host model: frames on the link, clock still between them
`timescale 1ns/1ns
module spi_host_model (
  // link
  output logic sclk,
  output logic enb_n,
  output logic sdin
);
  initial begin
    sclk  = 1'h0;
    enb_n = 1'h1;
    sdin  = 1'h0;
  end
  // frame carries data bits only; its length picks the target
  task automatic send(input int n, input logic [23:0] d,
                      input logic bytewise);
    int i;
    enb_n = 1'h0;
    #5;
    for (i = n - 1; i >= 0; i--) begin
      sdin = d[i];
      #6 sclk = 1'h1;
      #6 sclk = 1'h0;
      if (bytewise && i % 8 == 0) #30;
    end
    #6 enb_n = 1'h1;
    sdin = ~sdin; // released line must not show a stale bit
    #48;
  endtask
endmodule // spi_host_model

//--- bench/tb_top.sv
// self-checking bench: bus table, serial frames, jam and quiet outputs
`timescale 1ns/1ns
module tb_top
  import pll_pkg::*;
;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
  } row_s;
  logic        hclk = 1'h0, hresetn = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic        osc = 1'h0, hreadyout, hresp, sclk, enb_n, sdin;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, osc_div = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        fr_out, fv_out, phi_r_out, phi_v_out, lock_out, ref_out;
  int          num_errors, cmp_count, cyc, i, npulse, nr, nv, nref;
  row_s        rows [12] = '{
    '{1'h0, OFS_LOOP, 32'(LOOP_RST)}, '{1'h0, OFS_REF, 32'(REF_RST)},
    '{1'h0, OFS_CFG, 32'(CFG_RST)}, '{1'h0, 8'h10, 32'h0},
    '{1'h1, OFS_CFG, 32'hFFFFFF07}, '{1'h0, OFS_CFG, 32'h07},
    '{1'h1, OFS_REF, 32'hFFFF7FFF}, '{1'h0, OFS_REF, 32'h7FFF},
    '{1'h1, OFS_LOOP, 32'h1FFFF}, '{1'h0, OFS_LOOP, 32'hFFFF},
    '{1'h1, OFS_LOOP, 32'h28}, '{1'h0, OFS_LOOP, 32'h28}
  };

  pll_synth_core uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sclk(sclk), .enb_n(enb_n), .sdin(sdin),
    .osc_in(osc), .fin_in(osc), .fr_out(fr_out), .fv_out(fv_out),
    .phi_r_out(phi_r_out), .phi_v_out(phi_v_out), .lock_out(lock_out),
    .ref_out(ref_out)
  );
  spi_host_model host (.sclk(sclk), .enb_n(enb_n), .sdin(sdin));

  always #4 hclk = ~hclk;

  // one source feeds both dividers so equal ratios must stay in step
  always @(posedge hclk) begin
    osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
    if (osc_div == 2'h2) osc <= ~osc;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    r = hrdata;
  endtask

  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    // a real falling edge, so link-clock flops reset with no link clock
    hresetn <= 1'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (i = 0; i < 12; i++) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rd);
      if (!rows[i].w) check(rd, rows[i].d);
    end
    $display("bus table done");
    // bit framing to cfg, byte framing to loop, long frame to ref
    host.send(8, 24'h0F, 1'h0);
    @(posedge hclk);
    bus(1'h0, OFS_CFG, 32'h0, rd);
    check(rd, 32'h0F);
    host.send(16, 24'h30, 1'h1);
    @(posedge hclk);
    bus(1'h0, OFS_LOOP, 32'h0, rd);
    check(rd, 32'h30);
    host.send(24, 24'hFF0030, 1'h0);
    @(posedge hclk);
    bus(1'h0, OFS_REF, 32'h0, rd);
    check(rd, 32'h30);
    bus(1'h0, OFS_STATUS, 32'h0, rd);
    check({24'h0, rd[15:8]}, 32'h3);
    $display("serial frames done");
    // ref was loaded last without a jam, so only this write aligns them
    bus(1'h1, OFS_LOOP, 32'h30, rd);
    repeat (4) @(posedge hclk);
    npulse = 0;
    repeat (800) begin
      @(posedge hclk);
      check(32'(fr_out), 32'(fv_out));
      check(32'(phi_r_out), 32'(phi_v_out));
      npulse += int'(fr_out);
    end
    check(32'(npulse > 0), 32'h1);
    check(32'(lock_out), 32'h1);
    $display("jam test done");
    // ref twice as fast: only the up flag rises, shown on the swapped pin
    bus(1'h1, OFS_REF, 32'h18, rd);
    bus(1'h1, OFS_CFG, 32'h1F, rd);
    bus(1'h1, OFS_LOOP, 32'h30, rd);
    repeat (4) @(posedge hclk);
    nr = 0;
    nv = 0;
    nref = 0;
    repeat (600) begin
      @(posedge hclk);
      nr += int'(phi_r_out);
      nv += int'(phi_v_out);
      nref += int'(ref_out);
    end
    check(32'(nr), 32'h0);
    check(32'(nv > 0), 32'h1);
    check(32'(nref > 0), 32'h1);
    $display("detector swap done");
    bus(1'h1, OFS_CFG, 32'h0, rd);
    repeat (4) @(posedge hclk);
    repeat (100) begin
      @(posedge hclk);
      check({26'h0, fr_out, fv_out, phi_r_out, phi_v_out, lock_out,
             ref_out}, 32'h0);
    end
    $display("quiet outputs done");
    hresetn <= 1'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, OFS_LOOP, 32'h0, rd);
    check(rd, 32'(LOOP_RST));
    $display("reset test done");
    tally_and_finish();
  end
endmodule // tb_top
